// >>> client_model.sv
module client_model (
	// Client ends of request and response streams
	input wire logic clk,
	output logic [7:0] rxData,
	output logic rxValid,
	input wire logic rxReady,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txLast,
	output logic txReady);
	timeunit 1ns;
	timeprecision 1ps;
	initial {rxValid, rxData, txReady} = 10'h000;
	// Twelve bytes high byte first, idle line inverted, random stalls
	task automatic xfer(input logic [95:0] req, output logic [7:0] q[$]);
		bit done;
		for (int i = 0; i < 12; i++) begin
			{rxValid, rxData} = {1'b1, req[95 - 8 * i -: 8]};
			do @(posedge clk); while (rxReady !== 1'b1);
			#1;
		end
		{rxValid, rxData} = {1'b0, ~rxData};
		done = 1'b0;
		while (!done) begin
			txReady = 1'($urandom_range(0, 1));
			@(posedge clk);
			if (txValid === 1'b1 && txReady === 1'b1) begin
				q.push_back(txData);
				done = (txLast === 1'b1);
			end
			#1;
		end
		txReady = 1'b0;
	endtask
endmodule

// >>> modbus_read_pkg.sv
package modbus_read_pkg;
	localparam logic [7:0] FC_READ_BITS = 8'h01;
	localparam logic [7:0] FC_READ_FLOAT = 8'h03;
	localparam logic [7:0] FC_ERROR_FLAG = 8'h80;
	localparam logic [7:0] EXC_BAD_FUNCTION = 8'h01;
	localparam logic [7:0] EXC_BAD_ADDRESS = 8'h02;
	localparam logic [7:0] EXC_BAD_QUANTITY = 8'h03;
	localparam logic [7:0] EXC_DEVICE_FAIL = 8'h04;
	localparam logic [15:0] BIT_QTY_MIN = 16'h0001;
	localparam logic [15:0] BIT_QTY_MAX = 16'h07D0;
	localparam logic [15:0] REG_QTY_MIN = 16'h0002;
	localparam logic [15:0] REG_QTY_MAX = 16'h007C;
	localparam logic [15:0] PROTOCOL_MODBUS = 16'h0000;
	localparam logic [2:0] HDR_BYTES = 3'h7;
	localparam logic [2:0] PDU_REQ_BYTES = 3'h5;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RECV,
		ST_CHECK,
		ST_FETCH,
		ST_SEND
	} state_t;
endpackage

// >>> modbus_read_responder.sv
module modbus_read_responder
#(
	parameter int ADDR_W = 16
) (
	// System
	input wire logic clk,
	input wire logic rst,
	// Request byte stream (MBAP header then PDU)
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	output logic rxReady,
	// Response byte stream
	output logic [7:0] txData,
	output logic txValid,
	output logic txLast,
	input wire logic txReady,
	// Status bit store, read one bit per cycle
	output logic [ADDR_W-1:0] bitAddr,
	input wire logic bitValue,
	// Float register store, read one word per cycle
	output logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regValue,
	// Store fault, reported as exception 04
	input wire logic storeFault
);
	import modbus_read_pkg::*;

	state_t state_reg;
	logic [3:0] rxCount_reg;
	logic [7:0] hdr_reg [0:6];
	logic [7:0] func_reg;
	logic [15:0] start_reg;
	logic [15:0] qty_reg;
	logic [7:0] exc_reg;
	logic [8:0] byteCount_reg;
	logic [7:0] pdu_reg [0:511];
	logic [15:0] fetchIdx_reg;
	logic [8:0] sendIdx_reg;
	logic [8:0] sendLen_reg;
	logic [8:0] pickIdx;
	logic [7:0] txByte;
	logic [7:0] exc_next;
	logic [16:0] lastAddr;
	logic fetchDone;
	logic sendPrimed_reg;

	function automatic logic [7:0] bit_bytes(input logic [15:0] q);
		// Round up so a partial last byte is counted
		bit_bytes = 8'((q + 16'h0007) >> 3);
	endfunction

	assign rxReady = (state_reg == ST_IDLE) || (state_reg == ST_RECV);

	// Frame intake: seven header bytes then five PDU bytes, big-endian
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			rxCount_reg <= 4'h0;
			func_reg <= 8'h00;
			start_reg <= 16'h0000;
			qty_reg <= 16'h0000;
		end else begin
			case (state_reg)
				ST_IDLE, ST_RECV: begin
					if (rxValid) begin
						state_reg <= ST_RECV;
						rxCount_reg <= rxCount_reg + 4'h1;
						if (rxCount_reg < 4'(HDR_BYTES))
							hdr_reg[rxCount_reg[2:0]] <= rxData;
						case (rxCount_reg)
							4'h7: func_reg <= rxData;
							4'h8: start_reg[15:8] <= rxData;
							4'h9: start_reg[7:0] <= rxData;
							4'hA: qty_reg[15:8] <= rxData;
							4'hB: begin
								qty_reg[7:0] <= rxData;
								state_reg <= ST_CHECK;
							end
							default: ;
						endcase
					end
				end
				ST_CHECK: begin
					rxCount_reg <= 4'h0;
					state_reg <= (exc_next == 8'h00) ? ST_FETCH : ST_SEND;
				end
				ST_FETCH: begin
					if (fetchDone)
						state_reg <= ST_SEND;
				end
				ST_SEND: begin
					if (txReady && txLast)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Request validation
	always_comb begin
		lastAddr = {1'b0, start_reg} + {1'b0, qty_reg} - 17'h00001;
		exc_next = 8'h00;
		if (func_reg == FC_READ_BITS) begin
			if (qty_reg < BIT_QTY_MIN || qty_reg > BIT_QTY_MAX)
				exc_next = EXC_BAD_QUANTITY;
			else if (lastAddr[16])
				exc_next = EXC_BAD_ADDRESS;
		end else if (func_reg == FC_READ_FLOAT) begin
			if (qty_reg < REG_QTY_MIN || qty_reg > REG_QTY_MAX)
				exc_next = EXC_BAD_QUANTITY;
			else if (lastAddr[16])
				exc_next = EXC_BAD_ADDRESS;
		end else begin
			exc_next = EXC_BAD_FUNCTION;
		end
	end

	assign fetchDone = (func_reg == FC_READ_BITS) ? (fetchIdx_reg == qty_reg - 16'h0001)
		: (fetchIdx_reg == qty_reg - 16'h0001);

	// Addresses are wire addresses, already zero-based
	assign bitAddr = ADDR_W'(start_reg + fetchIdx_reg);
	assign regAddr = ADDR_W'(start_reg + fetchIdx_reg);

	// Data gathering into the response buffer
	always_ff @(posedge clk) begin
		if (rst) begin
			fetchIdx_reg <= 16'h0000;
			exc_reg <= 8'h00;
			byteCount_reg <= 9'h000;
		end else if (state_reg == ST_CHECK) begin
			fetchIdx_reg <= 16'h0000;
			exc_reg <= exc_next;
			if (func_reg == FC_READ_BITS)
				byteCount_reg <= {1'b0, bit_bytes(qty_reg)};
			else
				byteCount_reg <= 9'(qty_reg << 2);
			for (int i = 0; i < 512; i++)
				pdu_reg[i] <= 8'h00;
		end else if (state_reg == ST_FETCH) begin
			fetchIdx_reg <= fetchIdx_reg + 16'h0001;
			if (storeFault)
				exc_reg <= EXC_DEVICE_FAIL;
			if (func_reg == FC_READ_BITS) begin
				// LSB of first byte carries the first addressed bit
				pdu_reg[fetchIdx_reg[11:3]][fetchIdx_reg[2:0]] <= bitValue;
			end else begin
				pdu_reg[{fetchIdx_reg[6:0], 2'b00}] <= regValue[31:24];
				pdu_reg[{fetchIdx_reg[6:0], 2'b01}] <= regValue[23:16];
				pdu_reg[{fetchIdx_reg[6:0], 2'b10}] <= regValue[15:8];
				pdu_reg[{fetchIdx_reg[6:0], 2'b11}] <= regValue[7:0];
			end
		end
	end

	// Response length: header, function, then count plus data or one exception byte
	always_ff @(posedge clk) begin
		if (rst) begin
			sendIdx_reg <= 9'h000;
			sendLen_reg <= 9'h000;
		end else if (state_reg == ST_FETCH && fetchDone) begin
			sendIdx_reg <= 9'h000;
			sendLen_reg <= (exc_reg != 8'h00 || storeFault) ? 9'd9
				: 9'd9 + byteCount_reg;
		end else if (state_reg == ST_CHECK) begin
			sendIdx_reg <= 9'h000;
			sendLen_reg <= 9'd9;
		end else if (state_reg == ST_SEND && txValid && txReady) begin
			sendIdx_reg <= sendIdx_reg + 9'h001;
		end
	end

	// Length field counts unit id plus PDU
	logic [15:0] mbapLen;
	assign mbapLen = 16'(sendLen_reg) - 16'h0006;

	// Index of the byte txData must show after this edge, so a stall holds it steady
	assign pickIdx = (txValid && txReady) ? sendIdx_reg + 9'h001 : sendIdx_reg;

	always_comb begin
		case (pickIdx)
			9'd0: txByte = hdr_reg[0];
			9'd1: txByte = hdr_reg[1];
			9'd2: txByte = PROTOCOL_MODBUS[15:8];
			9'd3: txByte = PROTOCOL_MODBUS[7:0];
			9'd4: txByte = mbapLen[15:8];
			9'd5: txByte = mbapLen[7:0];
			9'd6: txByte = hdr_reg[6];
			9'd7: txByte = (exc_reg != 8'h00) ? (func_reg | FC_ERROR_FLAG) : func_reg;
			// One-byte count wraps above 63 float registers; the MBAP length still frames it
			9'd8: txByte = (exc_reg != 8'h00) ? exc_reg : byteCount_reg[7:0];
			default: txByte = pdu_reg[pickIdx - 9'd9];
		endcase
	end

	// Byte held in a flop so data output is registered
	always_ff @(posedge clk) begin
		if (rst)
			txData <= 8'h00;
		else
			txData <= txByte;
	end

	assign txValid = (state_reg == ST_SEND) && sendPrimed_reg;
	assign txLast = txValid && (sendIdx_reg == sendLen_reg - 9'h001);

	// One idle cycle before sending loads the first byte into txData
	always_ff @(posedge clk) begin
		if (rst)
			sendPrimed_reg <= 1'b0;
		else
			sendPrimed_reg <= (state_reg == ST_SEND);
	end
endmodule

// >>> modbus_read_responder_properties.sv
module modbus_read_responder_properties (
	// Response side, plus request-side rxReady
	input wire logic clk,
	input wire logic rst,
	input wire logic rxReady,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txLast,
	input wire logic txReady);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_hold; txValid && !txReady |=> txValid && $stable({txData, txLast}); endproperty
	a_hold: assert property (p_hold) else $error("stall lost");
	property p_lastv; txLast |-> txValid; endproperty
	a_lastv: assert property (p_lastv) else $error("bad last");
	property p_end; txValid && txReady && txLast |=> !txValid; endproperty
	a_end: assert property (p_end) else $error("extra byte");
	property p_idle; txValid && txReady && txLast |-> ##[1:3] rxReady; endproperty
	a_idle: assert property (p_idle) else $error("no idle");
	property p_excl; rxReady |-> !txValid; endproperty
	a_excl: assert property (p_excl) else $error("overlap");
	property p_cut; $fell(txValid) |-> $past(txReady) && $past(txLast); endproperty
	a_cut: assert property (p_cut) else $error("cut short");
	property p_gap; $fell(rxReady) |=> !txValid; endproperty
	a_gap: assert property (p_gap) else $error("early");
	property p_rise; $rose(txValid) |-> !$past(rxReady, 2); endproperty
	a_rise: assert property (p_rise) else $error("no prime");
	cover property (txValid && !txReady);
	cover property (txValid && txReady && txLast);
	cover property ($fell(rxReady));
endmodule

// >>> modbus_read_responder_test.sv
module modbus_read_responder_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, storeFault = 1'b0;
	logic rxValid, rxReady, txValid, txLast, txReady;
	logic [7:0] rxData, txData;
	logic [15:0] bitAddr, regAddr;
	int fails = 0, comparisons = 0;
	// Store patterns: bit is parity of address bits 0, 2 and 5, word is address XOR A5C3 above the address
	wire logic bitValue = ^(bitAddr & 16'h0025);
	wire logic [31:0] regValue = {regAddr ^ 16'hA5C3, regAddr};
	initial forever #5 clk = ~clk;
	modbus_read_responder i_modbus_read_responder (.clk(clk), .rst(rst), .rxData(rxData),
		.rxValid(rxValid), .rxReady(rxReady), .txData(txData), .txValid(txValid),
		.txLast(txLast), .txReady(txReady), .bitAddr(bitAddr), .bitValue(bitValue),
		.regAddr(regAddr), .regValue(regValue), .storeFault(storeFault));
	client_model i_client_model (.clk(clk), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
		.txData(txData), .txValid(txValid), .txLast(txLast), .txReady(txReady));
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		comparisons++;
		if (g !== x) $display("[ERR] %0t got %h exp %h", $time, g, x);
		fails += int'(g !== x);
	endtask
	task automatic print_verdict(input int hang);
		fails += hang;
		$display("Comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic run(input int f, input int s, input int n, input logic flt);
		logic [7:0] ex[$], got[$], b;
		logic [31:0] w, t;
		int e, bc, len;
		t = $urandom;
		storeFault = flt;
		e = (f != 1 && f != 3) ? 1 : (n < 1 + f / 3 || n > (f < 3 ? 2000 : 124)) ? 3 : 0;
		if (e == 0) e = (s + n > 65536) ? 2 : flt ? 4 : 0;
		bc = (f == 1) ? (n + 7) / 8 : 4 * n;
		len = e ? 3 : bc + 3;
		ex = {t[15:8], t[7:0], 8'h00, 8'h00, 8'(len >> 8), 8'(len), 8'h03,
			8'(f) | (e ? 8'h80 : 8'h00), 8'(e ? e : bc)};
		i_client_model.xfer({t[15:0], 32'h0000_0006, 8'h03, 8'(f), 16'(s), 16'(n)}, got);
		for (int i = 0; i < (e ? 0 : bc * 8); i++) begin
			w = {16'(s + i / 32) ^ 16'hA5C3, 16'(s + i / 32)};
			b[i % 8] = (f == 3) ? w[8 * (3 - i / 8 % 4) + i % 8] : i < n && ^((s + i) & 32'h25);
			if (i % 8 == 7) ex.push_back(b);
		end
		foreach (ex[i]) chk(got[i], ex[i]);
		comparisons++;
		if (got.size() != ex.size()) begin
			$display("[ERR] %0t got %h exp %h", $time, got.size(), ex.size());
			fails++;
		end
	endtask
	initial begin
		void'($urandom(32'h00A6));
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		run(1, 16'h0013, 19, 1'b0);
		run(1, $urandom_range(0, 63536), 2000, 1'b0);
		run(1, 16'hFFF0, 17, 1'b0);
		run(3, 16'hFFFE, 2, 1'b0);
		run(3, $urandom_range(0, 65000), 125, 1'b0);
		run(3, $urandom_range(0, 65412), 124, 1'b0);
		run(5, 0, 1, 1'b0);
		run(3, 16'h0100, 40, 1'b1);
		print_verdict(0);
	end
	initial #200000 print_verdict(1);
endmodule
bind modbus_read_responder modbus_read_responder_properties i_props (.clk(clk), .rst(rst),
	.rxReady(rxReady), .txData(txData), .txValid(txValid), .txLast(txLast), .txReady(txReady));
